/* File: rtl/nfcs_map.svh */
`ifndef NFCS_MAP_SVH
`define NFCS_MAP_SVH

// ----------------------------------------------------------------------
// Register indices and byte addresses
// ----------------------------------------------------------------------
`define NFCS_ADDR_W        12
`define NFCS_NUM_REGS      4
`define NFCS_IDX_A_HIGH    8'h1b
`define NFCS_IDX_A_LOW     8'h1c
`define NFCS_IDX_B_HIGH    8'h1d
`define NFCS_IDX_B_LOW     8'h1e
`define NFCS_IDX_STATUS    8'h40
`define NFCS_BYTE_ADDR(i)  ({2'h0, (i), 2'b00})

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define NFCS_REG_W         9
`define NFCS_COMMIT_BIT    8
`define NFCS_ENABLE_BIT    7
`define NFCS_HALF_MSB      6
`define NFCS_COEF_W        14
`define NFCS_MASK_FIRST    8'hff
`define NFCS_MASK_OTHER    8'h7f
`define NFCS_RESET_VAL     8'h00

// ----------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------
`define NFCS_RESP_OKAY     2'b00
`define NFCS_RESP_SLVERR   2'b10

`endif

/* File: rtl/nfcs_pkg.sv */
`default_nettype none
`include "nfcs_map.svh"

package nfcs_pkg;

    // Write request handed from the bus slave to the bank
    typedef struct packed {
        logic                    en;
        logic [`NFCS_ADDR_W-1:0] addr;
        logic [`NFCS_REG_W-1:0]  data;
        logic [1:0]              strb;
    } nfcs_wreq_t;

    // Bus slave state
    typedef struct packed {
        logic                    awready;
        logic                    wready;
        logic                    arready;
        logic                    aw_full;
        logic [`NFCS_ADDR_W-1:0] awaddr;
        logic                    w_full;
        logic [`NFCS_REG_W-1:0]  wdata;
        logic [1:0]              wstrb;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    rvalid;
        logic [`NFCS_REG_W-1:0]  rdata;
        logic [1:0]              rresp;
    } nfcs_axil_st_t;

    // Register bank state
    typedef struct packed {
        logic [`NFCS_NUM_REGS-1:0][7:0] stg;
        logic [`NFCS_NUM_REGS-1:0]      pend;
        logic                           en;
        logic [`NFCS_COEF_W-1:0]        coef_a;
        logic [`NFCS_COEF_W-1:0]        coef_b;
        logic                           commit;
    } nfcs_bank_st_t;

endpackage

`default_nettype wire

/* File: rtl/nfcs_axil.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nfcs_map.svh"

module nfcs_axil
    import nfcs_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic [`NFCS_ADDR_W-1:0] awaddr_in,
    input  wire logic                    awvalid_in,
    output logic                         awready_out,
    input  wire logic [31:0]             wdata_in,
    input  wire logic [3:0]              wstrb_in,
    input  wire logic                    wvalid_in,
    output logic                         wready_out,
    output logic [1:0]                   bresp_out,
    output logic                         bvalid_out,
    input  wire logic                    bready_in,
    input  wire logic [`NFCS_ADDR_W-1:0] araddr_in,
    input  wire logic                    arvalid_in,
    output logic                         arready_out,
    output logic [31:0]                  rdata_out,
    output logic [1:0]                   rresp_out,
    output logic                         rvalid_out,
    input  wire logic                    rready_in,
    output nfcs_wreq_t                   wreq_out,
    input  wire logic                    wr_hit_in,
    output logic [`NFCS_ADDR_W-1:0]      rd_addr_out,
    input  wire logic [`NFCS_REG_W-1:0]  rd_data_in,
    input  wire logic                    rd_hit_in
);

    nfcs_axil_st_t st_r;
    nfcs_axil_st_t st_nxt;
    logic          aw_take;
    logic          w_take;
    logic          fire;

    // ------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------
    // Address and data are held apart so either may come first
    always_comb begin
        st_nxt  = st_r;
        aw_take = awvalid_in && st_r.awready;
        w_take  = wvalid_in && st_r.wready;
        fire    = (st_r.aw_full || aw_take) && (st_r.w_full || w_take);
        if (aw_take) begin
            st_nxt.aw_full = 1'b1;
            st_nxt.awaddr  = awaddr_in;
        end
        if (w_take) begin
            st_nxt.w_full = 1'b1;
            st_nxt.wdata  = wdata_in[`NFCS_REG_W-1:0];
            st_nxt.wstrb  = wstrb_in[1:0];
        end
        if (st_r.bvalid && bready_in) begin
            st_nxt.bvalid = 1'b0;
        end
        if (fire) begin
            st_nxt.aw_full = 1'b0;
            st_nxt.w_full  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = wr_hit_in ? `NFCS_RESP_OKAY : `NFCS_RESP_SLVERR;
        end
        // Reads answer one edge after the address is taken
        if (st_r.rvalid && rready_in) begin
            st_nxt.rvalid = 1'b0;
        end
        if (arvalid_in && st_r.arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata  = rd_data_in;
            st_nxt.rresp  = rd_hit_in ? `NFCS_RESP_OKAY : `NFCS_RESP_SLVERR;
        end
        // Readies are registered so the bus sees flop outputs only
        st_nxt.awready = !st_nxt.aw_full && !st_nxt.bvalid;
        st_nxt.wready  = !st_nxt.w_full && !st_nxt.bvalid;
        st_nxt.arready = !st_nxt.rvalid;
    end

    // ------------------------------------------------------------------
    // Request to the bank
    // ------------------------------------------------------------------
    always_comb begin
        wreq_out.en   = fire;
        wreq_out.addr = st_r.aw_full ? st_r.awaddr : awaddr_in;
        wreq_out.data = st_r.w_full ? st_r.wdata
                                    : wdata_in[`NFCS_REG_W-1:0];
        wreq_out.strb = st_r.w_full ? st_r.wstrb : wstrb_in[1:0];
    end

    // Outputs
    assign awready_out = st_r.awready;
    assign wready_out  = st_r.wready;
    assign arready_out = st_r.arready;
    assign bvalid_out  = st_r.bvalid;
    assign bresp_out   = st_r.bresp;
    assign rvalid_out  = st_r.rvalid;
    assign rresp_out   = st_r.rresp;
    assign rdata_out   = {23'h0, st_r.rdata};
    assign rd_addr_out = araddr_in;

    // State register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/nfcs_top.sv */
// What this block does
// - A write with commit bit clear only stages the value as pending.
// - Commit bit set with the upper byte lane strobed: apply this write and all pending values at once.
// - Commit bit is write-only; it acts as a strobe and reads back zero.
// - Notch enable bit: zero bypasses the filter and is the reset state.
// - First coefficient: bits 13..7 from register one, 6..0 from two.
// - Second coefficient: bits 13..7 from register three, 6..0 from four.
`timescale 1ns/1ps
`default_nettype none
`include "nfcs_map.svh"

module nfcs_top
    import nfcs_pkg::*;
(
    input  wire logic                    clk_in,
    input  wire logic                    rst_in,
    input  wire logic [`NFCS_ADDR_W-1:0] s_axi_awaddr_in,
    input  wire logic                    s_axi_awvalid_in,
    output logic                         s_axi_awready_out,
    input  wire logic [31:0]             s_axi_wdata_in,
    input  wire logic [3:0]              s_axi_wstrb_in,
    input  wire logic                    s_axi_wvalid_in,
    output logic                         s_axi_wready_out,
    output logic [1:0]                   s_axi_bresp_out,
    output logic                         s_axi_bvalid_out,
    input  wire logic                    s_axi_bready_in,
    input  wire logic [`NFCS_ADDR_W-1:0] s_axi_araddr_in,
    input  wire logic                    s_axi_arvalid_in,
    output logic                         s_axi_arready_out,
    output logic [31:0]                  s_axi_rdata_out,
    output logic [1:0]                   s_axi_rresp_out,
    output logic                         s_axi_rvalid_out,
    input  wire logic                    s_axi_rready_in,
    output logic                         notch_enable_out,
    output logic [`NFCS_COEF_W-1:0]      notch_coef_a_out,
    output logic [`NFCS_COEF_W-1:0]      notch_coef_b_out,
    output logic                         notch_commit_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    nfcs_bank_st_t             st_r;
    nfcs_bank_st_t             st_nxt;
    nfcs_wreq_t                wreq;
    logic [`NFCS_NUM_REGS-1:0] wsel;
    logic [`NFCS_NUM_REGS-1:0] rsel;
    logic [`NFCS_NUM_REGS-1:0] commit_vec;
    logic                      commit_strobe_first;
    logic                      commit_strobe_second;
    logic                      commit_strobe_third;
    logic                      commit_strobe_fourth;
    logic                      commit_any;
    logic                      wr_hit;
    logic                      rd_hit;
    logic                      rd_status;
    logic [`NFCS_ADDR_W-1:0]   rd_addr;
    logic [`NFCS_REG_W-1:0]    rd_data;

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------
    nfcs_axil u_axil (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .awaddr_in   (s_axi_awaddr_in),
        .awvalid_in  (s_axi_awvalid_in),
        .awready_out (s_axi_awready_out),
        .wdata_in    (s_axi_wdata_in),
        .wstrb_in    (s_axi_wstrb_in),
        .wvalid_in   (s_axi_wvalid_in),
        .wready_out  (s_axi_wready_out),
        .bresp_out   (s_axi_bresp_out),
        .bvalid_out  (s_axi_bvalid_out),
        .bready_in   (s_axi_bready_in),
        .araddr_in   (s_axi_araddr_in),
        .arvalid_in  (s_axi_arvalid_in),
        .arready_out (s_axi_arready_out),
        .rdata_out   (s_axi_rdata_out),
        .rresp_out   (s_axi_rresp_out),
        .rvalid_out  (s_axi_rvalid_out),
        .rready_in   (s_axi_rready_in),
        .wreq_out    (wreq),
        .wr_hit_in   (wr_hit),
        .rd_addr_out (rd_addr),
        .rd_data_in  (rd_data),
        .rd_hit_in   (rd_hit)
    );

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    // The four registers sit on consecutive indices, word per index
    always_comb begin
        for (int i = 0; i < `NFCS_NUM_REGS; i++) begin
            wsel[i] = (wreq.addr ==
                       `NFCS_BYTE_ADDR(8'(`NFCS_IDX_A_HIGH + i)));
            rsel[i] = (rd_addr ==
                       `NFCS_BYTE_ADDR(8'(`NFCS_IDX_A_HIGH + i)));
        end
    end

    // Status word is read-only, so a write there is refused
    assign wr_hit    = |wsel;
    assign rd_status = (rd_addr == `NFCS_BYTE_ADDR(`NFCS_IDX_STATUS));
    assign rd_hit    = (|rsel) || rd_status;

    // ------------------------------------------------------------------
    // Commit strobes
    // ------------------------------------------------------------------
    // Strobe needs the upper byte lane, where the commit bit lives
    always_comb begin
        for (int i = 0; i < `NFCS_NUM_REGS; i++) begin
            commit_vec[i] = wsel[i] && wreq.en && wreq.strb[1]
                            && wreq.data[`NFCS_COMMIT_BIT];
        end
    end

    assign commit_strobe_first  = commit_vec[0];
    assign commit_strobe_second = commit_vec[1];
    assign commit_strobe_third  = commit_vec[2];
    assign commit_strobe_fourth = commit_vec[3];
    assign commit_any = commit_strobe_first | commit_strobe_second
                      | commit_strobe_third | commit_strobe_fourth;

    // ------------------------------------------------------------------
    // Staging and apply
    // ------------------------------------------------------------------
    // Applied values come from the next staging image, so the value of
    // the committing write itself joins the others in the same edge
    always_comb begin
        st_nxt        = st_r;
        st_nxt.commit = 1'b0;
        for (int i = 0; i < `NFCS_NUM_REGS; i++) begin
            if (wsel[i] && wreq.en && wreq.strb[0]) begin
                // Commit bit is never stored; bit 7 only where it exists
                st_nxt.stg[i] = wreq.data[7:0] & ((i == 0)
                                ? `NFCS_MASK_FIRST
                                : `NFCS_MASK_OTHER);
                st_nxt.pend[i] = 1'b1;
            end
        end
        if (commit_any) begin
            st_nxt.en     = st_nxt.stg[0][`NFCS_ENABLE_BIT];
            st_nxt.coef_a = {st_nxt.stg[0][`NFCS_HALF_MSB:0],
                             st_nxt.stg[1][`NFCS_HALF_MSB:0]};
            st_nxt.coef_b = {st_nxt.stg[2][`NFCS_HALF_MSB:0],
                             st_nxt.stg[3][`NFCS_HALF_MSB:0]};
            st_nxt.pend   = '0;
            st_nxt.commit = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    // Reads return the last written value, commit bit always zero
    always_comb begin
        rd_data = '0;
        for (int i = 0; i < `NFCS_NUM_REGS; i++) begin
            if (rsel[i]) begin
                rd_data = {1'b0, st_r.stg[i]};
            end
        end
        if (rd_status) begin
            rd_data = {4'h0, st_r.en, st_r.pend};
        end
    end

    // Outputs straight from the bank flops
    assign notch_enable_out = st_r.en;
    assign notch_coef_a_out = st_r.coef_a;
    assign notch_coef_b_out = st_r.coef_b;
    assign notch_commit_out = st_r.commit;

    // Bank state; reset leaves the filter bypassed
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_stage_write;
        wreq.en && wr_hit && !(wreq.strb[1] && wreq.data[`NFCS_COMMIT_BIT]);
    endsequence

    sequence s_commit_write;
        wreq.en && wr_hit && wreq.strb[1] && wreq.data[`NFCS_COMMIT_BIT];
    endsequence

    property p_stage_holds;
        @(posedge clk_in) disable iff (rst_in)
        s_stage_write |=> $stable(notch_coef_a_out)
            && $stable(notch_coef_b_out) && $stable(notch_enable_out);
    endproperty
    a_stage_holds: assert property (p_stage_holds)
        else $error("staged write changed applied values");

    property p_commit_applies;
        @(posedge clk_in) disable iff (rst_in)
        s_commit_write |=> notch_commit_out && st_r.pend == '0
            && notch_coef_a_out == {st_r.stg[0][6:0], st_r.stg[1][6:0]}
            && notch_coef_b_out == {st_r.stg[2][6:0], st_r.stg[3][6:0]};
    endproperty
    a_commit_applies: assert property (p_commit_applies)
        else $error("commit did not apply all staged values");

    property p_commit_reads_zero;
        @(posedge clk_in) disable iff (rst_in)
        (s_axi_arvalid_in && s_axi_arready_out && (|rsel))
            |=> s_axi_rvalid_out && !s_axi_rdata_out[`NFCS_COMMIT_BIT];
    endproperty
    a_commit_reads_zero: assert property (p_commit_reads_zero)
        else $error("commit bit read back as one");

    property p_enable_follows;
        @(posedge clk_in) disable iff (rst_in)
        !notch_commit_out |-> notch_enable_out == $past(notch_enable_out)
            || $past(rst_in);
    endproperty
    a_enable_follows: assert property (p_enable_follows)
        else $error("enable changed without a commit");

    property p_coef_a_layout;
        @(posedge clk_in) disable iff (rst_in)
        notch_commit_out |-> notch_coef_a_out[13:7] == st_r.stg[0][6:0]
            && notch_coef_a_out[6:0] == st_r.stg[1][6:0];
    endproperty
    a_coef_a_layout: assert property (p_coef_a_layout)
        else $error("first coefficient halves misplaced");

    property p_coef_b_layout;
        @(posedge clk_in) disable iff (rst_in)
        notch_commit_out |-> notch_coef_b_out[13:7] == st_r.stg[2][6:0]
            && notch_coef_b_out[6:0] == st_r.stg[3][6:0];
    endproperty
    a_coef_b_layout: assert property (p_coef_b_layout)
        else $error("second coefficient halves misplaced");

    property p_enable_bit_pos;
        @(posedge clk_in) disable iff (rst_in)
        notch_commit_out |-> notch_enable_out == st_r.stg[0][7]
            && st_r.stg[1][7] == 1'b0 && st_r.stg[3][7] == 1'b0;
    endproperty
    a_enable_bit_pos: assert property (p_enable_bit_pos)
        else $error("enable bit not at bit 7 of first register");

    // Writes are spaced by the bus, so a pulse never lasts two cycles
    property p_commit_on_strobe;
        @(posedge clk_in) disable iff (rst_in)
        notch_commit_out |-> $past(commit_any) ##1 !notch_commit_out;
    endproperty
    a_commit_on_strobe: assert property (p_commit_on_strobe)
        else $error("commit pulse without a commit write");

endmodule

`default_nettype wire

/* File: dv/nfcs_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "nfcs_map.svh"

module nfcs_top_tb_top
    import nfcs_pkg::*;
();
// ----------------------------------------------------------------------
// Stimulus, outputs and reference model
// ----------------------------------------------------------------------
logic                    clk_in;
logic                    rst_in;
logic [`NFCS_ADDR_W-1:0] awaddr;
logic [`NFCS_ADDR_W-1:0] araddr;
logic                    awvalid;
logic                    wvalid;
logic                    bready;
logic                    arvalid;
logic                    rready;
logic [31:0]             wdata;
logic [3:0]              wstrb;
logic                    awready;
logic                    wready;
logic                    bvalid;
logic                    arready;
logic                    rvalid;
logic [1:0]              bresp;
logic [1:0]              rresp;
logic [31:0]             rdata;
logic                    en;
logic [13:0]             ca;
logic [13:0]             cb;
logic                    cmt;
logic [7:0]              stg [4];
logic [3:0]              pend;
logic                    ap_en;
logic [13:0]             ap_a;
logic [13:0]             ap_b;
logic                    cmt_seen;
int                      n_fail;
int                      tests_run;

nfcs_top dut_u (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .s_axi_awaddr_in   (awaddr),
    .s_axi_awvalid_in  (awvalid),
    .s_axi_awready_out (awready),
    .s_axi_wdata_in    (wdata),
    .s_axi_wstrb_in    (wstrb),
    .s_axi_wvalid_in   (wvalid),
    .s_axi_wready_out  (wready),
    .s_axi_bresp_out   (bresp),
    .s_axi_bvalid_out  (bvalid),
    .s_axi_bready_in   (bready),
    .s_axi_araddr_in   (araddr),
    .s_axi_arvalid_in  (arvalid),
    .s_axi_arready_out (arready),
    .s_axi_rdata_out   (rdata),
    .s_axi_rresp_out   (rresp),
    .s_axi_rvalid_out  (rvalid),
    .s_axi_rready_in   (rready),
    .notch_enable_out  (en),
    .notch_coef_a_out  (ca),
    .notch_coef_b_out  (cb),
    .notch_commit_out  (cmt)
);

// Free-running 50 MHz clock
always #10 clk_in = ~clk_in;

// ----------------------------------------------------------------------
// Compare, report and bus tasks
// ----------------------------------------------------------------------
task automatic chk_word(input string nm, input logic [31:0] e,
                        input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask

task automatic chk_resp(input string nm, input logic [1:0] e,
                        input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
        n_fail++;
        $display("wrong value %s expected %h seen %h", nm, e, g);
    end
endtask

task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
        $display("Finished cleanly");
    else
        $display("Finished with errors");
    $finish;
endtask

// Handshakes judged at the negedge so the posedge outcome is known
task automatic axi_write(input logic [11:0] a, input logic [8:0] d,
                         input logic [3:0] s, output logic [1:0] r);
    logic aw_hit, w_hit, got;
    got = 1'b0;
    r = 2'h3;
    @(posedge clk_in);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {23'h0, d};
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int k = 0; k < 50 && !got; k++) begin
        @(negedge clk_in);
        aw_hit = awvalid && awready;
        w_hit  = wvalid && wready;
        got    = bvalid;
        r        = bresp;
        cmt_seen = cmt;
        @(posedge clk_in);
        if (aw_hit) awvalid <= 1'b0;
        if (w_hit) wvalid <= 1'b0;
        if (got) bready <= 1'b0;
    end
    if (!got) begin
        n_fail++;
        $display("wrong value write answer expected 1 seen 0");
        print_verdict();
    end
endtask

task automatic axi_read(input logic [11:0] a, output logic [31:0] v,
                        output logic [1:0] r);
    logic ar_hit, got;
    got = 1'b0;
    @(posedge clk_in);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int k = 0; k < 50 && !got; k++) begin
        @(negedge clk_in);
        ar_hit = arvalid && arready;
        got    = rvalid;
        v = rdata;
        r = rresp;
        @(posedge clk_in);
        if (ar_hit) arvalid <= 1'b0;
        if (got) rready <= 1'b0;
    end
    if (!got) begin
        n_fail++;
        $display("wrong value read answer expected 1 seen 0");
        print_verdict();
    end
endtask

function automatic logic [11:0] addr_of(input logic [1:0] i);
    logic [7:0] x;
    x = `NFCS_IDX_A_HIGH + {6'h0, i};
    return `NFCS_BYTE_ADDR(x);
endfunction

// ----------------------------------------------------------------------
// Model-driven helpers
// ----------------------------------------------------------------------
task automatic chk_out();
    @(negedge clk_in);
    chk_word("enable", {31'h0, ap_en}, {31'h0, en});
    chk_word("coef a", {18'h0, ap_a}, {18'h0, ca});
    chk_word("coef b", {18'h0, ap_b}, {18'h0, cb});
    chk_word("pulse end", 32'h0, {31'h0, cmt});
endtask

task automatic rd_chk(input logic [1:0] i);
    logic [31:0] v;
    logic [1:0]  r;
    axi_read(addr_of(i), v, r);
    chk_resp("read resp", `NFCS_RESP_OKAY, r);
    chk_word("readback", {24'h0, stg[i]}, v);
endtask

task automatic st_chk();
    logic [31:0] v;
    logic [1:0]  r;
    axi_read(`NFCS_BYTE_ADDR(`NFCS_IDX_STATUS), v, r);
    chk_resp("status resp", `NFCS_RESP_OKAY, r);
    chk_word("status", {27'h0, ap_en, pend}, v);
endtask

// Commit only when both the bit and its strobe lane are present
task automatic wr(input logic [1:0] i, input logic [8:0] d,
                  input logic [3:0] s);
    logic [1:0] r;
    logic       cm;
    axi_write(addr_of(i), d, s, r);
    chk_resp("write resp", `NFCS_RESP_OKAY, r);
    cm = d[8] & s[1];
    if (s[0]) stg[i] = d[7:0] & ((i == 2'd0) ? 8'hff : 8'h7f);
    if (s[0] && !cm) pend[i] = 1'b1;
    if (cm) begin
        pend  = 4'h0;
        ap_en = stg[0][7];
        ap_a  = {stg[0][6:0], stg[1][6:0]};
        ap_b  = {stg[2][6:0], stg[3][6:0]};
    end
    chk_word("commit pulse", {31'h0, cm}, {31'h0, cmt_seen});
    chk_out();
    rd_chk(i);
endtask

// ----------------------------------------------------------------------
// Scenarios
// ----------------------------------------------------------------------
task automatic t_reset();
    chk_out();
    for (int i = 0; i < 4; i++) rd_chk(2'(i));
    st_chk();
    $display("test reset done");
endtask

task automatic t_stage_commit();
    wr(2'd0, 9'h0d5, 4'h3);
    wr(2'd1, 9'h02a, 4'h1);
    wr(2'd2, 9'h011, 4'h3);
    st_chk();
    wr(2'd3, 9'h122, 4'h3);
    st_chk();
    $display("test stage and commit done");
endtask

// Each register's strobe, with a neighbour staged just before
task automatic t_each_strobe();
    logic [7:0] pat [4];
    pat = '{8'h7f, 8'h01, 8'h40, 8'h3c};
    for (int i = 0; i < 4; i++) begin
        wr(2'(i + 1), {1'b0, pat[3 - i]}, 4'h3);
        wr(2'(i), {1'b1, pat[i]}, 4'h3);
    end
    wr(2'd0, 9'h1a5, 4'h1);
    wr(2'd2, 9'h155, 4'h2);
    $display("test each strobe done");
endtask

task automatic t_bad_access();
    logic [31:0] v;
    logic [1:0]  r;
    axi_write(12'h080, 9'h1ff, 4'h3, r);
    chk_resp("unmapped write", `NFCS_RESP_SLVERR, r);
    chk_word("no pulse", 32'h0, {31'h0, cmt_seen});
    axi_write(`NFCS_BYTE_ADDR(`NFCS_IDX_STATUS), 9'h1ff, 4'h3, r);
    chk_resp("status write", `NFCS_RESP_SLVERR, r);
    chk_word("no pulse", 32'h0, {31'h0, cmt_seen});
    chk_out();
    axi_read(12'h080, v, r);
    chk_resp("unmapped read", `NFCS_RESP_SLVERR, r);
    chk_word("unmapped data", 32'h0, v);
    st_chk();
    $display("test bad access done");
endtask

// Main sequence: reset, scenarios, verdict
initial begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    for (int i = 0; i < 4; i++) stg[i] = 8'h00;
    {pend, ap_en, ap_a, ap_b, cmt_seen} = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_stage_commit();
    t_each_strobe();
    t_bad_access();
    print_verdict();
end

endmodule
`default_nettype wire
